// file: common/owc_pkg.sv
// Constants of the oscillator and warm-up control block.
// What this block and the software that drives it must do
// R1: Bits 31-20 of oscillator control hold the warm-up count time.
// R2: Warm-up source select bit 19: 0 internal, 1 external oscillator.
// R3: Bit 18 hands the crystal pins to the port (0) or oscillator (1).
// R4: With crystal pins assigned, shared port registers are blocked and read zero.
// R5: Crystal assignment refused while a shared port register differs from reset.
// R6: Bit 17 selects the high-speed source: 0 internal, 1 external.
// R7: Software confirms external selected, stops internal oscillator, never reselects internal.
// R8: Bit 16 stops (0) or runs (1) the internal oscillator.
// R9: Bit 8 stops (0) or runs (1) the external oscillator.
// R10: Software always writes zero to the auxiliary warm-up source bit.
// R11: Bit 2 runs the PLL when set; it clears on reset.
// R12: Read-only busy bit 1 reads one while warm-up counts.
// R13: Writing one to bit 0 starts warm-up; writing zero does nothing.
// R14: Software must not start warm-up when stop return uses automatic warm-up.
// R15: Software waits for busy clear before requesting stop mode.
// R16: Standby stop pin drive: 0 pins inactive, 1 pins active in stop.
// R17: Effective warm-up count is the field value times sixteen.
// R18: The clock fed to PLL and gear follows the high-speed source select.
// R19: Start sets busy, counts source cycles to the duration, then clears busy.
package owc_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] OSC_CTRL_OFS = 8'h04;
  localparam logic [7:0] STANDBY_MODE_SELECT_CTRL_OFS = 8'h08;
  localparam logic [7:0] IRQ_STATUS_OFS = 8'h20;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h24;

  // ----------------------------------------------------------------
  // Oscillator control fields
  // ----------------------------------------------------------------
  localparam int WU_TIME_LSB = 20;
  localparam int WU_TIME_W = 12;
  localparam int WU_SRC_BIT = 19;
  localparam int XTAL_PIN_BIT = 18;
  localparam int HS_SRC_BIT = 17;
  localparam int INT_EN_BIT = 16;
  localparam int EXT_EN_BIT = 8;
  localparam int WU_AUX_BIT = 3;
  localparam int PLL_RUN_BIT = 2;
  localparam int WU_BUSY_BIT = 1;
  localparam int WU_START_BIT = 0;
  localparam int WU_DROP_BITS = 4;
  localparam logic [11:0] WU_TIME_RST = 12'h800;
  localparam logic INT_EN_RST = 1'b1;

  // ----------------------------------------------------------------
  // Standby control fields
  // ----------------------------------------------------------------
  localparam int STOP_DRIVE_BIT = 16;
  localparam int RESUME_EN_BIT = 8;
  localparam int STANDBY_MODE_SELECT_MODE_LSB = 0;
  localparam int STANDBY_MODE_SELECT_MODE_W = 3;
  localparam logic STOP_DRIVE_RST = 1'b0;
  localparam logic RESUME_EN_RST = 1'b1;
  localparam logic [2:0] STANDBY_MODE_SELECT_MODE_RST = 3'h3;

  // ----------------------------------------------------------------
  // Interrupt status bits
  // ----------------------------------------------------------------
  localparam int IRQ_W = 2;
  localparam int IRQ_WU_DONE = 0;
  localparam int IRQ_XTAL_REFUSED = 1;

endpackage

// file: design/owc_tick_sync.sv
// Two-flop synchroniser with rising-edge pulse for oscillator tick pins.
`timescale 1ns/10ps
module owc_tick_sync #(
  parameter int W = 2
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Asynchronous levels and their synchronised edges
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] rise_o
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;
  logic [W-1:0] last_q;

  // The edge detector looks at the second and third stages only.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      meta_q <= '0;
      sync_q <= '0;
      last_q <= '0;
      rise_o <= '0;
    end else begin
      meta_q <= async_i;
      sync_q <= meta_q;
      last_q <= sync_q;
      rise_o <= sync_q & ~last_q;
    end
  end

endmodule

// file: design/owc_top.sv
// Oscillator enables, source selection, crystal pin hand-over and warm-up control.
//
// Design decisions made here: strobed register access and the address map.
`timescale 1ns/10ps
module owc_top (
  // Clock and reset
  input wire logic CLK_I,
  input wire logic RESETN_I,
  // Register port
  input wire logic [owc_pkg::ADDR_W-1:0] ADDR_I,
  input wire logic [31:0] WDATA_I,
  input wire logic WRITE_I,
  input wire logic READ_I,
  output logic [31:0] RDATA_O,
  // Oscillator tick pins, asynchronous
  input wire logic INT_OSC_TICK_I,
  input wire logic EXT_OSC_TICK_I,
  // Shared port logic, same clock
  input wire logic PORT_NOT_DEFAULT_I,
  output logic PORT_ACCESS_BLOCK_O,
  // Oscillator and PLL control
  output logic INT_OSC_EN_O,
  output logic EXT_OSC_EN_O,
  output logic HS_SOURCE_SEL_O,
  output logic XTAL_PIN_ASSIGN_O,
  output logic PLL_RUN_O,
  // Standby control
  output logic STOP_PIN_DRIVE_O,
  output logic RESUME_OSC_EN_O,
  output logic [owc_pkg::STANDBY_MODE_SELECT_MODE_W-1:0] STANDBY_MODE_O,
  // Warm-up and interrupt
  output logic WARMUP_BUSY_O,
  output logic IRQ_O
);

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [owc_pkg::WU_TIME_W-1:0] warmup_count_time_q;
  logic warmup_source_select_q;
  logic warmup_source_aux_q;
  logic crystal_pin_assign_q;
  logic highspeed_source_select_q;
  logic internal_osc_enable_q;
  logic external_osc_enable_q;
  logic pll_run_q;
  logic stop_pin_drive_q;
  logic resume_osc_enable_q;
  logic [owc_pkg::STANDBY_MODE_SELECT_MODE_W-1:0] standby_mode_select_q;
  logic [owc_pkg::IRQ_W-1:0] irq_status_q;
  logic [owc_pkg::IRQ_W-1:0] irq_mask_q;
  logic [owc_pkg::IRQ_W-1:0] irq_event;
  logic [31:0] rdata_d;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  logic wr_osc;
  logic wr_standby_mode_select;
  logic wr_status;
  logic wr_mask;
  logic pin_request;
  logic pin_refused;
  logic warmup_start;
  logic [1:0] osc_rise;
  logic warmup_tick;
  logic warmup_busy;
  logic warmup_done;

  function automatic logic hit(input logic strobe, input logic [owc_pkg::ADDR_W-1:0] addr,
                               input logic [owc_pkg::ADDR_W-1:0] ofs);
    hit = strobe && (addr == ofs);
  endfunction

  assign wr_osc = hit(WRITE_I, ADDR_I, owc_pkg::OSC_CTRL_OFS);
  assign wr_standby_mode_select = hit(WRITE_I, ADDR_I, owc_pkg::STANDBY_MODE_SELECT_CTRL_OFS);
  assign wr_status = hit(WRITE_I, ADDR_I, owc_pkg::IRQ_STATUS_OFS);
  assign wr_mask = hit(WRITE_I, ADDR_I, owc_pkg::IRQ_MASK_OFS);

  // A rise of the pin assignment is refused while the port is not at reset.
  assign pin_request = wr_osc && WDATA_I[owc_pkg::XTAL_PIN_BIT] && !crystal_pin_assign_q;
  assign pin_refused = pin_request && PORT_NOT_DEFAULT_I; // R5

  // Only a written one starts the timer; a zero leaves it alone.
  assign warmup_start = wr_osc && WDATA_I[owc_pkg::WU_START_BIT]; // R13

  // ----------------------------------------------------------------
  // Warm-up source ticks
  // ----------------------------------------------------------------
  owc_tick_sync #(
    .W(2)
  ) u_sync (
    .clk_i(CLK_I),
    .resetn_i(RESETN_I),
    .async_i({EXT_OSC_TICK_I, INT_OSC_TICK_I}),
    .rise_o(osc_rise)
  );

  // Bit one of the pair is the external oscillator, bit zero the internal.
  assign warmup_tick = warmup_source_select_q ? osc_rise[1] : osc_rise[0]; // R2

  owc_warmup_timer #(
    .TIME_W(owc_pkg::WU_TIME_W),
    .DROP(owc_pkg::WU_DROP_BITS)
  ) u_timer (
    .clk_i(CLK_I),
    .resetn_i(RESETN_I),
    .start_i(warmup_start),
    .tick_i(warmup_tick),
    .time_i(warmup_count_time_q), // R1
    .busy_o(warmup_busy),
    .done_o(warmup_done)
  );

  // ----------------------------------------------------------------
  // Oscillator control register
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      warmup_count_time_q <= owc_pkg::WU_TIME_RST;
      warmup_source_select_q <= 1'b0;
      warmup_source_aux_q <= 1'b0;
      highspeed_source_select_q <= 1'b0;
      internal_osc_enable_q <= owc_pkg::INT_EN_RST;
      external_osc_enable_q <= 1'b0;
      pll_run_q <= 1'b0; // R11
    end else if (wr_osc) begin
      warmup_count_time_q <= WDATA_I[owc_pkg::WU_TIME_LSB +: owc_pkg::WU_TIME_W]; // R1
      warmup_source_select_q <= WDATA_I[owc_pkg::WU_SRC_BIT]; // R2
      // Held as written; the timer ignores it, software keeps it at zero.
      warmup_source_aux_q <= WDATA_I[owc_pkg::WU_AUX_BIT]; // R10
      highspeed_source_select_q <= WDATA_I[owc_pkg::HS_SRC_BIT]; // R6
      internal_osc_enable_q <= WDATA_I[owc_pkg::INT_EN_BIT]; // R8
      external_osc_enable_q <= WDATA_I[owc_pkg::EXT_EN_BIT]; // R9
      pll_run_q <= WDATA_I[owc_pkg::PLL_RUN_BIT]; // R11
    end
  end

  // The pin hand-over has its own process because of the refusal path.
  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      crystal_pin_assign_q <= 1'b0;
    end else if (wr_osc && !pin_refused) begin
      crystal_pin_assign_q <= WDATA_I[owc_pkg::XTAL_PIN_BIT]; // R3
    end
  end

  // ----------------------------------------------------------------
  // Standby control register
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      stop_pin_drive_q <= owc_pkg::STOP_DRIVE_RST;
      resume_osc_enable_q <= owc_pkg::RESUME_EN_RST;
      standby_mode_select_q <= owc_pkg::STANDBY_MODE_SELECT_MODE_RST;
    end else if (wr_standby_mode_select) begin
      stop_pin_drive_q <= WDATA_I[owc_pkg::STOP_DRIVE_BIT]; // R16
      resume_osc_enable_q <= WDATA_I[owc_pkg::RESUME_EN_BIT];
      standby_mode_select_q <= WDATA_I[owc_pkg::STANDBY_MODE_SELECT_MODE_LSB +: owc_pkg::STANDBY_MODE_SELECT_MODE_W];
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status and mask
  // ----------------------------------------------------------------
  assign irq_event = {pin_refused, warmup_done};

  // A new event in the clearing cycle survives the write of one.
  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      irq_status_q <= '0;
    end else begin
      irq_status_q <= (irq_status_q & ~(wr_status ? WDATA_I[owc_pkg::IRQ_W-1:0] : '0)) | irq_event;
    end
  end

  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      irq_mask_q <= '0;
    end else if (wr_mask) begin
      irq_mask_q <= WDATA_I[owc_pkg::IRQ_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (READ_I) begin
      unique case (ADDR_I)
        owc_pkg::OSC_CTRL_OFS: begin
          rdata_d[owc_pkg::WU_TIME_LSB +: owc_pkg::WU_TIME_W] = warmup_count_time_q;
          rdata_d[owc_pkg::WU_SRC_BIT] = warmup_source_select_q;
          rdata_d[owc_pkg::XTAL_PIN_BIT] = crystal_pin_assign_q;
          rdata_d[owc_pkg::HS_SRC_BIT] = highspeed_source_select_q; // R7
          rdata_d[owc_pkg::INT_EN_BIT] = internal_osc_enable_q;
          rdata_d[owc_pkg::EXT_EN_BIT] = external_osc_enable_q;
          rdata_d[owc_pkg::WU_AUX_BIT] = warmup_source_aux_q;
          rdata_d[owc_pkg::PLL_RUN_BIT] = pll_run_q;
          // A start written just before counts as busy already.
          rdata_d[owc_pkg::WU_BUSY_BIT] = warmup_busy; // R12
        end
        owc_pkg::STANDBY_MODE_SELECT_CTRL_OFS: begin
          rdata_d[owc_pkg::STOP_DRIVE_BIT] = stop_pin_drive_q;
          rdata_d[owc_pkg::RESUME_EN_BIT] = resume_osc_enable_q;
          rdata_d[owc_pkg::STANDBY_MODE_SELECT_MODE_LSB +: owc_pkg::STANDBY_MODE_SELECT_MODE_W] = standby_mode_select_q;
        end
        owc_pkg::IRQ_STATUS_OFS: begin
          rdata_d[owc_pkg::IRQ_W-1:0] = irq_status_q;
        end
        owc_pkg::IRQ_MASK_OFS: begin
          rdata_d[owc_pkg::IRQ_W-1:0] = irq_mask_q;
        end
        default: begin
          rdata_d = 32'h0000_0000;
        end
      endcase
    end
  end

  // Read data stand for exactly the cycle after the strobe.
  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      RDATA_O <= 32'h0000_0000;
    end else begin
      RDATA_O <= rdata_d;
    end
  end

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      INT_OSC_EN_O <= owc_pkg::INT_EN_RST;
      EXT_OSC_EN_O <= 1'b0;
      HS_SOURCE_SEL_O <= 1'b0;
      XTAL_PIN_ASSIGN_O <= 1'b0;
      PORT_ACCESS_BLOCK_O <= 1'b0;
      PLL_RUN_O <= 1'b0;
      STOP_PIN_DRIVE_O <= owc_pkg::STOP_DRIVE_RST;
      RESUME_OSC_EN_O <= owc_pkg::RESUME_EN_RST;
      STANDBY_MODE_O <= owc_pkg::STANDBY_MODE_SELECT_MODE_RST;
      WARMUP_BUSY_O <= 1'b0;
      IRQ_O <= 1'b0;
    end else begin
      INT_OSC_EN_O <= internal_osc_enable_q; // R8
      EXT_OSC_EN_O <= external_osc_enable_q; // R9
      HS_SOURCE_SEL_O <= highspeed_source_select_q; // R18
      XTAL_PIN_ASSIGN_O <= crystal_pin_assign_q; // R3
      // The port logic gates its accesses and forces reads to zero on this level.
      PORT_ACCESS_BLOCK_O <= crystal_pin_assign_q; // R4
      PLL_RUN_O <= pll_run_q; // R11
      STOP_PIN_DRIVE_O <= stop_pin_drive_q; // R16
      RESUME_OSC_EN_O <= resume_osc_enable_q;
      STANDBY_MODE_O <= standby_mode_select_q;
      WARMUP_BUSY_O <= warmup_busy; // R12
      IRQ_O <= |(irq_status_q & irq_mask_q);
    end
  end

endmodule

// file: design/owc_warmup_timer.sv
// Warm-up counter that counts source-clock ticks up to a programmed duration.
`timescale 1ns/10ps
module owc_warmup_timer #(
  parameter int TIME_W = 12,
  parameter int DROP = 4
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Control
  input wire logic start_i,
  input wire logic tick_i,
  input wire logic [TIME_W-1:0] time_i,
  // Status
  output logic busy_o,
  output logic done_o
);

  localparam int CNT_W = TIME_W + DROP;

  logic [CNT_W-1:0] target_q;
  logic [CNT_W-1:0] count_q;
  logic [CNT_W-1:0] count_d;

  assign count_d = count_q + CNT_W'(1);

  // The duration is latched at start so a later write cannot shorten a run.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      target_q <= '0;
      count_q <= '0;
      busy_o <= 1'b0;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (start_i) begin
        target_q <= {time_i, {DROP{1'b0}}}; // R17
        count_q <= '0;
        busy_o <= 1'b1; // R19
      end else if (busy_o && tick_i) begin
        count_q <= count_d; // R19
        if (count_d >= target_q) begin
          busy_o <= 1'b0; // R19
          done_o <= 1'b1;
        end
      end
    end
  end

endmodule

// file: dv/owc_monitor.sv
// Concurrent checks on the ports of the oscillator and warm-up control block.
`timescale 1ns/10ps
module owc_monitor (
  // Clock and reset
  input wire logic CLK_I,
  input wire logic RESETN_I,
  // Register port
  input wire logic [owc_pkg::ADDR_W-1:0] ADDR_I,
  input wire logic [31:0] WDATA_I,
  input wire logic WRITE_I,
  input wire logic READ_I,
  input wire logic [31:0] RDATA_O,
  // Oscillator ticks and shared port
  input wire logic INT_OSC_TICK_I,
  input wire logic EXT_OSC_TICK_I,
  input wire logic PORT_NOT_DEFAULT_I,
  input wire logic PORT_ACCESS_BLOCK_O,
  // Oscillator, PLL and standby controls
  input wire logic INT_OSC_EN_O,
  input wire logic EXT_OSC_EN_O,
  input wire logic HS_SOURCE_SEL_O,
  input wire logic XTAL_PIN_ASSIGN_O,
  input wire logic PLL_RUN_O,
  input wire logic STOP_PIN_DRIVE_O,
  input wire logic RESUME_OSC_EN_O,
  input wire logic [owc_pkg::STANDBY_MODE_SELECT_MODE_W-1:0] STANDBY_MODE_O,
  // Warm-up and interrupt
  input wire logic WARMUP_BUSY_O,
  input wire logic IRQ_O
);
  logic wr_osc;
  logic start_w;
  logic rd_osc;
  assign wr_osc = WRITE_I && (ADDR_I == owc_pkg::OSC_CTRL_OFS);
  assign start_w = wr_osc && WDATA_I[owc_pkg::WU_START_BIT];
  assign rd_osc = READ_I && (ADDR_I == owc_pkg::OSC_CTRL_OFS);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RESETN_I);

  start_busy_a: assert property (start_w |-> ##2 WARMUP_BUSY_O)
    else $error("warm-up start did not raise busy");
  zero_start_a: assert property (
    (wr_osc && !WDATA_I[0] && !WARMUP_BUSY_O && !$past(start_w)) |-> ##2 !WARMUP_BUSY_O)
    else $error("writing zero to the start bit raised busy");
  pll_follow_a: assert property (wr_osc |-> ##2 PLL_RUN_O == $past(WDATA_I[2], 2))
    else $error("PLL run output does not follow its bit");
  osc_enable_a: assert property (
    wr_osc |-> ##2 {INT_OSC_EN_O, EXT_OSC_EN_O} == $past({WDATA_I[16], WDATA_I[8]}, 2))
    else $error("oscillator enables do not follow their bits");
  hs_source_a: assert property (wr_osc |-> ##2 HS_SOURCE_SEL_O == $past(WDATA_I[17], 2))
    else $error("high-speed source select does not follow its bit");
  xtal_take_a: assert property (
    (wr_osc && !PORT_NOT_DEFAULT_I) |-> ##2 XTAL_PIN_ASSIGN_O == $past(WDATA_I[18], 2))
    else $error("crystal pin assignment does not follow its bit");
  xtal_refuse_a: assert property (
    (wr_osc && WDATA_I[18] && PORT_NOT_DEFAULT_I && !XTAL_PIN_ASSIGN_O && !$past(wr_osc))
    |-> ##2 !XTAL_PIN_ASSIGN_O)
    else $error("crystal pins taken while the port is not at reset");
  block_copy_a: assert property (PORT_ACCESS_BLOCK_O == XTAL_PIN_ASSIGN_O)
    else $error("port block differs from crystal pin assignment");
  busy_read_a: assert property (rd_osc |=> RDATA_O[1] == WARMUP_BUSY_O)
    else $error("busy bit read back differs from busy output");
  start_read_a: assert property (rd_osc |=> RDATA_O[0] == 1'b0)
    else $error("start bit did not read as zero");
  stop_drive_a: assert property (
    (WRITE_I && ADDR_I == owc_pkg::STANDBY_MODE_SELECT_CTRL_OFS) |-> ##2 STOP_PIN_DRIVE_O == $past(WDATA_I[16], 2))
    else $error("stop pin drive does not follow its bit");
endmodule

// file: dv/tb_top.sv
// Self-checking testbench of the oscillator and warm-up control block.
`timescale 1ns/10ps
module tb_top;
  typedef struct packed {logic [31:0] wd; logic [31:0] rdv; logic [5:0] outs;} owc_row_t;
  logic CLK_I = 1'b0;
  logic RESETN_I = 1'b0;
  logic [7:0] ADDR_I = 8'h00;
  logic [31:0] WDATA_I = 32'h0;
  logic WRITE_I = 1'b0;
  logic READ_I = 1'b0;
  logic INT_OSC_TICK_I = 1'b0;
  logic EXT_OSC_TICK_I = 1'b0;
  logic PORT_NOT_DEFAULT_I = 1'b0;
  logic [31:0] RDATA_O;
  logic PORT_ACCESS_BLOCK_O, INT_OSC_EN_O, EXT_OSC_EN_O, HS_SOURCE_SEL_O, XTAL_PIN_ASSIGN_O;
  logic PLL_RUN_O, STOP_PIN_DRIVE_O, RESUME_OSC_EN_O, WARMUP_BUSY_O, IRQ_O;
  logic [2:0] STANDBY_MODE_O;
  logic [1:0] int_cnt = 2'h0;
  logic [1:0] ext_cnt = 2'h0;
  int error_cnt = 0;
  int samples_checked = 0;
  wire [5:0] outs = {INT_OSC_EN_O, EXT_OSC_EN_O, HS_SOURCE_SEL_O, XTAL_PIN_ASSIGN_O, PORT_ACCESS_BLOCK_O, PLL_RUN_O};
  wire [4:0] standby_mode_select = {STOP_PIN_DRIVE_O, RESUME_OSC_EN_O, STANDBY_MODE_O};
  // The internal source stays selected here, so the switch-over is left for the end of the run.
  owc_row_t rows [4] = '{'{32'h0011_0104, 32'h0011_0104, 6'b110001}, '{32'h123c_0100, 32'h123c_0100, 6'b010110},
    '{32'hfff0_fef0, 32'hfff0_0000, 6'b000000}, '{32'h0001_0004, 32'h0001_0004, 6'b100001}};

  owc_top i_dut (.*);

  always #5 CLK_I = ~CLK_I;

  // ----------------------------------------------------------------
  // Oscillator models
  // ----------------------------------------------------------------
  // Internal runs at an eighth and external at a sixth of the clock, so each
  // level lasts at least three cycles, and a disabled oscillator stays low.
  always @(posedge CLK_I) begin
    int_cnt <= (int_cnt == 2'h3) ? 2'h0 : int_cnt + 2'h1;
    ext_cnt <= (ext_cnt == 2'h2) ? 2'h0 : ext_cnt + 2'h1;
    if (int_cnt == 2'h3) INT_OSC_TICK_I <= INT_OSC_EN_O & ~INT_OSC_TICK_I;
    if (ext_cnt == 2'h2) EXT_OSC_TICK_I <= EXT_OSC_EN_O & ~EXT_OSC_TICK_I;
  end

  // ----------------------------------------------------------------
  // Bus and checking tasks
  // ----------------------------------------------------------------
  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK_I);
    ADDR_I <= a;
    WDATA_I <= d;
    WRITE_I <= 1'b1;
    @(posedge CLK_I);
    WRITE_I <= 1'b0;
  endtask

  task automatic rdchk(input string name, input logic [7:0] a, input logic [31:0] exp);
    @(posedge CLK_I);
    ADDR_I <= a;
    READ_I <= 1'b1;
    @(posedge CLK_I);
    READ_I <= 1'b0;
    #1;
    check(name, RDATA_O, exp);
  endtask

  // Outputs are one flop behind the register, so they settle one edge after a write.
  task automatic settle();
    @(posedge CLK_I);
    #1;
  endtask

  task automatic warmup(input logic [31:0] cfg, input int lo, input int hi);
    int n;
    wr(owc_pkg::OSC_CTRL_OFS, cfg);
    wr(owc_pkg::OSC_CTRL_OFS, cfg | 32'h1);
    settle();
    check("busy_on", 32'(WARMUP_BUSY_O), 32'h1);
    rdchk("busy_rd", owc_pkg::OSC_CTRL_OFS, cfg | 32'h2);
    n = 2;
    while (WARMUP_BUSY_O === 1'b1 && n < 600) begin
      @(posedge CLK_I);
      #1;
      n++;
    end
    if (n >= 600) begin
      error_cnt++;
      print_verdict();
    end
    check("wu_len", 32'(n >= lo && n <= hi), 32'h1);
    rdchk("wu_done", owc_pkg::IRQ_STATUS_OFS, 32'h1);
    check("irq_wu", 32'(IRQ_O), 32'h1);
    wr(owc_pkg::IRQ_STATUS_OFS, 32'h1);
    wr(owc_pkg::OSC_CTRL_OFS, cfg);
    settle();
    check("no_start", 32'(WARMUP_BUSY_O), 32'h0);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge CLK_I);
    RESETN_I <= 1'b1;
    settle();
    check("outs_rst", 32'(outs), 32'h20);
    check("standby_mode_select_rst", 32'(standby_mode_select), 32'h0b);
    rdchk("osc_rst", owc_pkg::OSC_CTRL_OFS, 32'h8001_0000);
    rdchk("standby_mode_select_rd0", owc_pkg::STANDBY_MODE_SELECT_CTRL_OFS, 32'h0000_0103);
    rdchk("unmapped", 8'h10, 32'h0);
    foreach (rows[i]) begin
      wr(owc_pkg::OSC_CTRL_OFS, rows[i].wd);
      settle();
      check("outs", 32'(outs), 32'(rows[i].outs));
      rdchk("osc", owc_pkg::OSC_CTRL_OFS, rows[i].rdv);
    end
    wr(owc_pkg::STANDBY_MODE_SELECT_CTRL_OFS, 32'hffff_ffff);
    settle();
    check("standby_mode_select_on", 32'(standby_mode_select), 32'h1f);
    rdchk("standby_mode_select_rd1", owc_pkg::STANDBY_MODE_SELECT_CTRL_OFS, 32'h0001_0107);
    wr(owc_pkg::STANDBY_MODE_SELECT_CTRL_OFS, 32'h0);
    settle();
    check("standby_mode_select_off", 32'(standby_mode_select), 32'h0);
    // Crystal pins asked for while the port is not at reset.
    @(posedge CLK_I);
    PORT_NOT_DEFAULT_I <= 1'b1;
    wr(owc_pkg::OSC_CTRL_OFS, 32'h0004_0004);
    settle();
    check("xtal_ref", 32'(outs), 32'h01);
    rdchk("osc_ref", owc_pkg::OSC_CTRL_OFS, 32'h0000_0004);
    rdchk("irq_st", owc_pkg::IRQ_STATUS_OFS, 32'h2);
    check("irq_mask", 32'(IRQ_O), 32'h0);
    wr(owc_pkg::IRQ_MASK_OFS, 32'h3);
    settle();
    check("irq_on", 32'(IRQ_O), 32'h1);
    wr(owc_pkg::IRQ_STATUS_OFS, 32'h2);
    settle();
    check("irq_clr", 32'(IRQ_O), 32'h0);
    PORT_NOT_DEFAULT_I <= 1'b0;
    // Internal source, 16 ticks of 8 cycles; external source, 32 ticks of 6.
    warmup(32'h0011_0100, 120, 132);
    warmup(32'h0029_0100, 186, 196);
    // Switch to the external source, confirm it, then stop the internal oscillator.
    wr(owc_pkg::OSC_CTRL_OFS, 32'h0003_0100);
    rdchk("hs_ext", owc_pkg::OSC_CTRL_OFS, 32'h0003_0100);
    wr(owc_pkg::OSC_CTRL_OFS, 32'h0002_0100);
    settle();
    check("outs_ext", 32'(outs), 32'h18);
    print_verdict();
  end
endmodule

bind owc_top owc_monitor i_mon (.*);
